//--- lapc_defs.svh
`ifndef LAPC_DEFS_SVH
`define LAPC_DEFS_SVH

// register offsets on the control bus
`define LAPC_OFS_PHASE 7'h55
`define LAPC_OFS_CTL1 7'h56
`define LAPC_OFS_CTL2 7'h57

// reset values
`define LAPC_RST_PHASE 8'h00
`define LAPC_RST_CTL1 8'h00
`define LAPC_RST_CTL2 8'h00

// field positions
`define LAPC_CTL1_EN 7
`define LAPC_CTL1_TGT_HI 6
`define LAPC_CTL1_TGT_LO 4
`define LAPC_CTL1_WMASK 8'hF0
`define LAPC_CTL2_HYS_HI 7
`define LAPC_CTL2_HYS_LO 6
`define LAPC_CTL2_NOISE_HI 5
`define LAPC_CTL2_NOISE_LO 1
`define LAPC_CTL2_CLIP 0

// decoding constants, levels in tenths of a dB (negative magnitudes)
`define LAPC_HYS_OFF 2'b11
`define LAPC_NOISE_OFF 5'h00
`define LAPC_NOISE_BASE 10'd280
`define LAPC_NOISE_STEP 10'd20

// delay line geometry and the lag common to both channels
`define LAPC_DLY_DEPTH 256
`define LAPC_DLY_AW 8
`define LAPC_BASE_LAG 8'h01

`endif

//--- lapc_pkg.sv
package lapc_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } lapc_req_s;

    typedef struct packed {
        logic agc_en;
        logic [9:0] target_tenth_db;
        logic hys_en;
        logic [2:0] hys_db;
        logic noise_en;
        logic [9:0] noise_tenth_db;
        logic clip_step;
    } lapc_agc_cfg_s;
endpackage

//--- lapc_delay_mem.sv
`timescale 1ns/1ps
// small sample store; read data comes out of a register
module lapc_delay_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic sys_clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    // -----------------------------------------------------------------
    // storage and registered read
    // -----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

//--- lapc_top.sv
`timescale 1ns/1ps
`include "lapc_defs.svh"
module lapc_top #(
    parameter int SW = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire lapc_pkg::lapc_req_s req,
    output logic [7:0] rdata,
    output logic rvalid,
    input wire logic mod_tick,
    input wire logic [SW-1:0] left_in,
    input wire logic [SW-1:0] right_in,
    output logic [SW-1:0] left_out,
    output logic [SW-1:0] right_out,
    output lapc_pkg::lapc_agc_cfg_s agc_cfg
);
    import lapc_pkg::*;

    // -----------------------------------------------------------------
    // decode helpers
    // -----------------------------------------------------------------
    function automatic logic [9:0] target_lvl(input logic [2:0] c);
        case (c)
            3'h0: target_lvl = 10'd55;
            3'h1: target_lvl = 10'd80;
            3'h2: target_lvl = 10'd100;
            3'h3: target_lvl = 10'd120;
            3'h4: target_lvl = 10'd140;
            3'h5: target_lvl = 10'd170;
            3'h6: target_lvl = 10'd200;
            default: target_lvl = 10'd240;
        endcase
    endfunction

    function automatic logic [2:0] hys_lvl(input logic [1:0] c);
        case (c)
            2'b00: hys_lvl = 3'd1;
            2'b01: hys_lvl = 3'd2;
            2'b10: hys_lvl = 3'd4;
            default: hys_lvl = 3'd0;
        endcase
    endfunction

    // read slot for a given lag; the base lag keeps the lookup behind
    // the slot that the current tick is about to overwrite
    function automatic logic [7:0] tap(input logic [7:0] w,
        input logic [7:0] lag);
        tap = 8'(w - `LAPC_BASE_LAG - lag);
    endfunction

    // -----------------------------------------------------------------
    // register file
    // -----------------------------------------------------------------
    logic [7:0] phase_q, phase_d;
    logic [7:0] ctl1_q, ctl1_d;
    logic [7:0] ctl2_q, ctl2_d;
    logic [7:0] rdata_d;
    logic rvalid_d;

    // writes; reserved low bits of control one are never stored
    always_comb begin
        phase_d = phase_q;
        ctl1_d = ctl1_q;
        ctl2_d = ctl2_q;
        if (req.wr) begin
            if (req.addr == `LAPC_OFS_PHASE) begin
                phase_d = req.wdata;
            end else if (req.addr == `LAPC_OFS_CTL1) begin
                ctl1_d = req.wdata & `LAPC_CTL1_WMASK;
            end else if (req.addr == `LAPC_OFS_CTL2) begin
                ctl2_d = req.wdata;
            end
        end
    end

    // reads; unmapped offsets return zero
    always_comb begin
        rvalid_d = req.rd;
        rdata_d = 8'h00;
        if (req.addr == `LAPC_OFS_PHASE) begin
            rdata_d = phase_q;
        end else if (req.addr == `LAPC_OFS_CTL1) begin
            rdata_d = ctl1_q & `LAPC_CTL1_WMASK;
        end else if (req.addr == `LAPC_OFS_CTL2) begin
            rdata_d = ctl2_q;
        end
        if (!req.rd) begin
            rdata_d = 8'h00;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            phase_q <= `LAPC_RST_PHASE;
            ctl1_q <= `LAPC_RST_CTL1;
            ctl2_q <= `LAPC_RST_CTL2;
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            phase_q <= phase_d;
            ctl1_q <= ctl1_d;
            ctl2_q <= ctl2_d;
            rdata <= rdata_d;
            rvalid <= rvalid_d;
        end
    end

    // -----------------------------------------------------------------
    // gain loop configuration decode
    // -----------------------------------------------------------------
    lapc_agc_cfg_s cfg_d;
    logic [4:0] ncode;

    // registered so the loop sees a glitch-free setting
    always_comb begin
        ncode = ctl2_q[`LAPC_CTL2_NOISE_HI:`LAPC_CTL2_NOISE_LO];
        cfg_d.agc_en = ctl1_q[`LAPC_CTL1_EN];
        cfg_d.target_tenth_db =
            target_lvl(ctl1_q[`LAPC_CTL1_TGT_HI:`LAPC_CTL1_TGT_LO]);
        cfg_d.hys_db =
            hys_lvl(ctl2_q[`LAPC_CTL2_HYS_HI:`LAPC_CTL2_HYS_LO]);
        cfg_d.hys_en = ctl2_q[`LAPC_CTL2_HYS_HI:`LAPC_CTL2_HYS_LO]
            != `LAPC_HYS_OFF;
        cfg_d.noise_en = ncode != `LAPC_NOISE_OFF;
        cfg_d.noise_tenth_db = `LAPC_NOISE_BASE
            + `LAPC_NOISE_STEP * {5'h00, ncode};
        if (!cfg_d.noise_en) begin
            cfg_d.noise_tenth_db = 10'd0;
        end
        cfg_d.clip_step = ctl2_q[`LAPC_CTL2_CLIP];
        if (!cfg_d.agc_en) begin
            cfg_d.clip_step = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            agc_cfg <= '0;
        end else begin
            agc_cfg <= cfg_d;
        end
    end

    // -----------------------------------------------------------------
    // phase alignment, one slot per modulator tick
    // -----------------------------------------------------------------
    // both channels pass a delay line; the lagging side is delayed by
    // the offset magnitude, the other by zero. a base latency of one
    // slot is common to both so zero offset keeps them aligned.
    // the store is read before the tick writes it, so the newest slot
    // the read side may use is one behind the write pointer; reading
    // the write slot itself would return a sample a full lap old.
    localparam int DLY_DEPTH = `LAPC_DLY_DEPTH;
    localparam int DLY_AW = `LAPC_DLY_AW;
    logic [7:0] wptr_q, wptr_d;
    logic [7:0] lptr, rptr;
    logic [7:0] mag;
    logic lead_left;
    logic [SW-1:0] lmem, rmem;

    // negative offsets hold the right channel back instead
    always_comb begin
        wptr_d = mod_tick ? wptr_q + 8'h01 : wptr_q;
        lead_left = phase_q[7];
        mag = lead_left ? 8'(-phase_q) : phase_q;
        lptr = tap(wptr_q, 8'h00);
        rptr = tap(wptr_q, 8'h00);
        if (lead_left) begin
            rptr = tap(wptr_q, mag);
        end else begin
            lptr = tap(wptr_q, mag);
        end
    end

    // write pointer wraps freely; only its distance to the taps matters
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wptr_q <= 8'h00;
        end else begin
            wptr_q <= wptr_d;
        end
    end

    lapc_delay_mem #(.WIDTH(SW), .DEPTH(DLY_DEPTH), .AW(DLY_AW)) u_lmem (
        .sys_clk(sys_clk),
        .we(mod_tick),
        .waddr(wptr_q),
        .wdata(left_in),
        .raddr(lptr),
        .rdata(lmem)
    );

    lapc_delay_mem #(.WIDTH(SW), .DEPTH(DLY_DEPTH), .AW(DLY_AW)) u_rmem (
        .sys_clk(sys_clk),
        .we(mod_tick),
        .waddr(wptr_q),
        .wdata(right_in),
        .raddr(rptr),
        .rdata(rmem)
    );

    // outputs update on the tick after the store lookup
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            left_out <= '0;
            right_out <= '0;
        end else if (mod_tick) begin
            left_out <= lmem;
            right_out <= rmem;
        end
    end
endmodule

//--- lapc_properties.sv
`timescale 1ns/1ps
// ----
// port checks
// ----
module lapc_properties #(
    parameter int SW = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire lapc_pkg::lapc_req_s req,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic mod_tick,
    input wire logic [SW-1:0] left_in,
    input wire logic [SW-1:0] right_in,
    input wire logic [SW-1:0] left_out,
    input wire logic [SW-1:0] right_out,
    input wire lapc_pkg::lapc_agc_cfg_s agc_cfg
);
    import lapc_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // code tables of the gain loop, target levels in tenths of a dB, hysteresis in whole dB
    localparam logic [9:0] TGT [8] = '{10'd55, 10'd80, 10'd100, 10'd120,
        10'd140, 10'd170, 10'd200, 10'd240};
    localparam logic [2:0] HYS [4] = '{3'd1, 3'd2, 3'd4, 3'd0};
    // every read gets exactly one answer, one cycle later
    a_read_answer: assert property (req.rd |=> rvalid)
        else $error("read not answered");
    a_answer_cause: assert property (rvalid |-> $past(req.rd))
        else $error("answer without read");
    a_idle_rdata: assert property (!rvalid |-> rdata == 8'h00)
        else $error("read data not idle");
    a_ctl1_low_zero: assert property (
        req.rd && req.addr == 7'h56 |=> rdata[3:0] == 4'h0)
        else $error("reserved bits not zero");
    // settings show two cycles after the write; later writes land later
    a_enable_follows: assert property (
        req.wr && req.addr == 7'h56
        |-> ##2 agc_cfg.agc_en == $past(req.wdata[7], 2))
        else $error("enable wrong");
    a_target_set: assert property (
        req.wr && req.addr == 7'h56
        |-> ##2 agc_cfg.target_tenth_db == TGT[$past(req.wdata[6:4], 2)])
        else $error("bad target");
    a_hys_follows: assert property (
        req.wr && req.addr == 7'h57
        |-> ##2 agc_cfg.hys_db == HYS[$past(req.wdata[7:6], 2)]
        && agc_cfg.hys_en == ($past(req.wdata[7:6], 2) != 2'b11))
        else $error("hysteresis setting wrong");
    a_noise_follows: assert property (
        req.wr && req.addr == 7'h57 && req.wdata[5:1] != 5'h00
        |-> ##2 agc_cfg.noise_tenth_db
        == 10'd280 + 10'd20 * {5'h00, $past(req.wdata[5:1], 2)})
        else $error("noise threshold wrong");
    a_hys_codes: assert property (agc_cfg.hys_en ?
        agc_cfg.hys_db inside {3'd1, 3'd2, 3'd4} : agc_cfg.hys_db == 3'd0)
        else $error("bad hysteresis");
    a_noise_off: assert property (
        !agc_cfg.noise_en |-> agc_cfg.noise_tenth_db == 10'd0)
        else $error("noise level while off");
    a_noise_span: assert property (agc_cfg.noise_en |->
        agc_cfg.noise_tenth_db inside {[10'd300:10'd900]}
        && agc_cfg.noise_tenth_db % 20 == 0)
        else $error("bad noise level");
    a_clip_gated: assert property (
        !agc_cfg.agc_en |-> !agc_cfg.clip_step)
        else $error("clip step while off");
endmodule
bind lapc_top lapc_properties #(.SW(SW)) i_chk (.sys_clk(sys_clk),
    .rst_n(rst_n), .req(req), .rdata(rdata), .rvalid(rvalid),
    .mod_tick(mod_tick), .left_in(left_in), .right_in(right_in),
    .left_out(left_out), .right_out(right_out), .agc_cfg(agc_cfg));

//--- lapc_host.sv
`timescale 1ns/1ps
// ----
// host side of the control bus
// ----
module lapc_host (
    input wire logic sys_clk,
    output lapc_pkg::lapc_req_s req,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    import lapc_pkg::*;
    logic ok = 1'b0;
    initial req = '0;
    // idle lines carry inverted values so stale data is never reused
    task automatic xfer(input logic w, input logic [6:0] a,
        input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge sys_clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        // the answer stands for the cycle after the request edge
        @(posedge sys_clk);
        q = rdata;
        ok = rvalid == !w;
    endtask
endmodule

//--- lapc_top_tb_top.sv
`timescale 1ns/1ps
module lapc_top_tb_top;
    import lapc_pkg::*;
    logic sys_clk, rst_n, mod_tick, rvalid;
    logic [15:0] samp, left_out, right_out;
    logic [7:0] rdata, q;
    lapc_req_s req;
    lapc_agc_cfg_s agc_cfg;
    int err_total = 0, tests_run = 0, cyc = 0;
    logic [9:0] tgt [8] = '{55, 80, 100, 120, 140, 170, 200, 240};
    logic [2:0] hy [4] = '{1, 2, 4, 0};
    logic [4:0] nz [4] = '{0, 1, 2, 31};
    logic [7:0] ph [4] = '{8'h00, 8'h03, 8'h7F, 8'h80};
    lapc_top #(.SW(16)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .req(req), .rdata(rdata), .rvalid(rvalid), .mod_tick(mod_tick),
        .left_in(samp), .right_in(samp), .left_out(left_out),
        .right_out(right_out), .agc_cfg(agc_cfg));
    lapc_host i_host (.sys_clk(sys_clk), .req(req), .rdata(rdata),
        .rvalid(rvalid));
    // ----
    // clock, sample ramp and hang guard
    // ----
    initial begin
        sys_clk = 0;
        forever #4 sys_clk = ~sys_clk;
    end
    // same ramp on both channels, so any skew is the programmed offset
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        mod_tick <= !mod_tick;
        if (mod_tick) samp <= samp + 16'h0001;
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_host.xfer(1'b1, a, d, q);
        repeat (3) @(negedge sys_clk);
    endtask
    task automatic wrap_up();
        $display("errors %0d in %0d checks", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ----
    // register sequence
    // ----
    initial begin
        rst_n = 0; mod_tick = 0; samp = 0;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1;
        for (int a = 'h55; a <= 'h58; a++) begin
            i_host.xfer(1'b0, 7'(a), 8'h00, q);
            chk(q, 0);
            chk(i_host.ok, 1);
        end
        wr(7'h56, 8'hFF); // reserved bits set on purpose
        i_host.xfer(1'b0, 7'h56, 8'h00, q);
        chk(q, 16'h00F0);
        for (int c = 0; c < 8; c++) begin
            wr(7'h56, {1'b1, 3'(c), 4'h0});
            chk(agc_cfg.agc_en, 1);
            chk(agc_cfg.target_tenth_db, tgt[c]);
        end
        for (int i = 0; i < 4; i++) begin
            wr(7'h57, {2'(i), nz[i], i[0]});
            chk(agc_cfg.hys_db, hy[i]);
            chk(agc_cfg.hys_en, i != 3);
            chk(agc_cfg.noise_en, nz[i] != 0);
            chk(agc_cfg.noise_tenth_db, nz[i] ? 280 + 20 * nz[i] : 0);
            chk(agc_cfg.clip_step, i[0]);
        end
        wr(7'h56, 8'h00);
        chk(agc_cfg.agc_en, 0);
        chk(agc_cfg.clip_step, 0);
        // long wait lets the delay line refill past the largest offset
        for (int i = 0; i < 4; i++) begin
            wr(7'h55, ph[i]);
            i_host.xfer(1'b0, 7'h55, 8'h00, q);
            chk(q, ph[i]);
            chk(i_host.ok, 1);
            repeat (600) @(negedge sys_clk);
            chk(right_out - left_out, {{8{ph[i][7]}}, ph[i]});
        end
        wrap_up();
    end
endmodule
